// file: fdio_defs.vh
// constants of the fieldbus digital i/o slave application block
// assumes inclusion by bare name from the design file
`ifndef FDIO_DEFS_VH
`define FDIO_DEFS_VH

// register byte offsets on the avalon slave
`define FDIO_STATE_REQ_OFS 6'h00
`define FDIO_STATE_REP_OFS 6'h04
`define FDIO_ERR_CODE_OFS 6'h08
`define FDIO_CONFIG_OFS 6'h0C
`define FDIO_OUT_DATA_OFS 6'h10
`define FDIO_IN_DATA_OFS 6'h14
`define FDIO_IO_STATUS_OFS 6'h18
`define FDIO_SAFE_VAL_OFS 6'h1C
`define FDIO_OUT_USE_OFS 6'h20
`define FDIO_DELAYS_OFS 6'h24
`define FDIO_RESTORE_OFS 6'h28

// state field encodings
`define FDIO_ST_INIT 4'h1
`define FDIO_ST_PREOP 4'h2
`define FDIO_ST_BOOT 4'h3
`define FDIO_ST_SAFEOP 4'h4
`define FDIO_ST_OP 4'h8

// report and request word field positions
`define FDIO_ERR_FLAG_BIT 4
`define FDIO_ACK_BIT 4

// config register bit positions
`define FDIO_CFG_DC_MODE 0
`define FDIO_CFG_MBX_OK 1
`define FDIO_CFG_SYNC_OK 2
`define FDIO_CFG_OUT_OK 3
`define FDIO_CFG_IN_OK 4
`define FDIO_CFG_RESET 5'h1E

// error codes
`define FDIO_EC_NONE 16'h0000
`define FDIO_EC_UNSPEC 16'h0001
`define FDIO_EC_BAD_CHANGE 16'h0011
`define FDIO_EC_UNKNOWN 16'h0012
`define FDIO_EC_MBX_BOOT 16'h0015
`define FDIO_EC_MBX_PREOP 16'h0016
`define FDIO_EC_SYNC_CFG 16'h0017
`define FDIO_EC_SYNC_WDOG 16'h001B
`define FDIO_EC_OUT_CFG 16'h001D
`define FDIO_EC_IN_CFG 16'h001E

// emergency message codes
`define FDIO_EM_SUPPLY_BASE 16'h3001
`define FDIO_EM_OVERTEMP 16'h4001
`define FDIO_EM_RESET 16'h0000
`define FDIO_EM_SUPPLY_BIT 2
`define FDIO_EM_TEMP_BIT 4
`define FDIO_EM_OVERTEMP_IDX 5

// defaults and timing
`define FDIO_RESTORE_KEY 32'h00000001
`define FDIO_DELAY_RESET 32'h00000000
`define FDIO_LINK_TIMEOUT_US 1000
`define FDIO_CLK_MHZ 50

`endif

// file: fdio_slave_app.v
// fieldbus digital i/o slave: state machine, process data, emergencies
// assumes one 50 mhz clock, a master on avalon-mm and synchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "fdio_defs.vh"

// ----------------------------------------------------------------------
// Overview of operation
// ----------------------------------------------------------------------
module fdio_slave_app #(
  parameter LINK_TIMEOUT_CYCLES =
    `FDIO_LINK_TIMEOUT_US * `FDIO_CLK_MHZ,
  parameter CHANNELS = 16
) (
  input wire clock_i,
  input wire resetn_i,
  // avalon-mm slave
  input wire [5:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // sync events, link supervision and application fault
  input wire frame_sync_event_i,
  input wire first_sync_pulse_i,
  input wire link_activity_i,
  input wire sync_watchdog_i,
  input wire app_fault_i,
  // channel pins
  input wire [CHANNELS-1:0] chan_in_i,
  output wire [CHANNELS-1:0] chan_out_o,
  output wire [CHANNELS-1:0] chan_out_en_o,
  // supply and temperature faults
  input wire [5:0] io_fault_i,
  input wire [5:0] supply_fault_i,
  // emergency messages
  output wire emcy_valid_o,
  output wire [63:0] emcy_frame_o,
  input wire emcy_ready_i,
  // defaults restore request for the next power-on, link timeout flag
  output wire restore_defaults_o,
  output wire link_timeout_o
);

  // --------------------------------------------------------------------
  // register state
  // --------------------------------------------------------------------
  reg [3:0] state_r, state_nxt;
  reg err_flag_r, err_flag_nxt;
  reg [15:0] err_code_r, err_code_nxt;
  reg [4:0] config_r;
  reg [CHANNELS-1:0] out_data_r;
  reg [CHANNELS-1:0] safe_val_r;
  reg [CHANNELS-1:0] out_use_r;
  reg [31:0] delays_r;
  reg restore_r;
  reg [31:0] rdata_r;
  reg ack_r;
  reg [CHANNELS-1:0] pin_out_r;
  reg [CHANNELS-1:0] pin_in_r;
  reg [15:0] out_cnt_r;
  reg out_busy_r;
  reg [15:0] in_cnt_r;
  reg in_busy_r;
  reg [31:0] wdog_cnt_r;
  reg timeout_r;
  reg [5:0] fault_rep_r;
  reg emcy_valid_r;
  reg [63:0] emcy_frame_r;
  reg [2:0] emcy_idx_r;

  wire access = avs_read_i | avs_write_i;
  wire wr_take = avs_write_i & ack_r;
  wire rd_take = avs_read_i & ~ack_r;
  wire req_wr = wr_take & (avs_address_i == `FDIO_STATE_REQ_OFS);
  wire [3:0] req_state = avs_writedata_i[3:0];
  wire req_ack = avs_writedata_i[`FDIO_ACK_BIT];
  wire dc_mode = config_r[`FDIO_CFG_DC_MODE];
  wire mbx_ok = config_r[`FDIO_CFG_MBX_OK];
  wire sync_ok = config_r[`FDIO_CFG_SYNC_OK];
  wire out_ok = config_r[`FDIO_CFG_OUT_OK];
  wire in_ok = config_r[`FDIO_CFG_IN_OK];
  wire run_state = (state_r == `FDIO_ST_OP) |
    (state_r == `FDIO_ST_SAFEOP);

  // --------------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // --------------------------------------------------------------------
  // waitrequest drops in the second cycle of each access
  assign avs_waitrequest_o = access & ~ack_r;
  assign avs_readdata_o = rdata_r;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access & ~ack_r;
    end
  end

  // read data mux, unmapped reads return zero
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 32'h00000000;
    end else if (rd_take) begin
      case (avs_address_i)
        `FDIO_STATE_REQ_OFS: rdata_r <= {28'h0000000, state_r};
        `FDIO_STATE_REP_OFS: rdata_r <= {27'h0000000, err_flag_r, state_r};
        `FDIO_ERR_CODE_OFS: rdata_r <= {16'h0000, err_code_r};
        `FDIO_CONFIG_OFS: rdata_r <= {27'h0000000, config_r};
        `FDIO_OUT_DATA_OFS: rdata_r <= {16'h0000, out_data_r};
        `FDIO_IN_DATA_OFS: rdata_r <= {16'h0000, pin_in_r};
        `FDIO_IO_STATUS_OFS: rdata_r <= {26'h0000000, io_fault_i};
        `FDIO_SAFE_VAL_OFS: rdata_r <= {16'h0000, safe_val_r};
        `FDIO_OUT_USE_OFS: rdata_r <= {16'h0000, out_use_r};
        `FDIO_DELAYS_OFS: rdata_r <= delays_r;
        `FDIO_RESTORE_OFS: rdata_r <= {31'h00000000, restore_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  // writable registers
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      config_r <= `FDIO_CFG_RESET;
      out_data_r <= {CHANNELS{1'b0}};
      safe_val_r <= {CHANNELS{1'b0}};
      out_use_r <= {CHANNELS{1'b0}};
      delays_r <= `FDIO_DELAY_RESET;
      restore_r <= 1'b0;
    end else if (wr_take) begin
      case (avs_address_i)
        `FDIO_CONFIG_OFS: config_r <= avs_writedata_i[4:0];
        `FDIO_OUT_DATA_OFS: out_data_r <= avs_writedata_i[CHANNELS-1:0];
        `FDIO_SAFE_VAL_OFS: safe_val_r <= avs_writedata_i[CHANNELS-1:0];
        `FDIO_OUT_USE_OFS: out_use_r <= avs_writedata_i[CHANNELS-1:0];
        `FDIO_DELAYS_OFS: delays_r <= avs_writedata_i;
        `FDIO_RESTORE_OFS:
          restore_r <= (avs_writedata_i == `FDIO_RESTORE_KEY);
        default: restore_r <= restore_r;
      endcase
    end
  end

  assign restore_defaults_o = restore_r;

  // --------------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------------
  // request write attempts transition
  always @* begin
    state_nxt = state_r;
    err_flag_nxt = err_flag_r;
    err_code_nxt = err_code_r;
    if (req_wr) begin
      if (req_state != `FDIO_ST_INIT && req_state != `FDIO_ST_PREOP &&
          req_state != `FDIO_ST_BOOT && req_state != `FDIO_ST_SAFEOP &&
          req_state != `FDIO_ST_OP) begin
        err_flag_nxt = 1'b1;
        err_code_nxt = `FDIO_EC_UNKNOWN;
      end else if (req_state == state_r) begin
        // acknowledge clears a pending error
        if (req_ack) begin
          err_flag_nxt = 1'b0;
          err_code_nxt = `FDIO_EC_NONE;
        end
      end else begin
        case (state_r)
          `FDIO_ST_INIT: begin
            if (req_state == `FDIO_ST_SAFEOP || req_state == `FDIO_ST_OP) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_BAD_CHANGE;
            end else if (!mbx_ok) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = (req_state == `FDIO_ST_BOOT) ?
                `FDIO_EC_MBX_BOOT : `FDIO_EC_MBX_PREOP;
            end else begin
              state_nxt = req_state;
              err_flag_nxt = 1'b0;
              err_code_nxt = `FDIO_EC_NONE;
            end
          end
          `FDIO_ST_PREOP: begin
            if (req_state == `FDIO_ST_OP || req_state == `FDIO_ST_BOOT) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_BAD_CHANGE;
            end else if (req_state == `FDIO_ST_SAFEOP && !sync_ok) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_SYNC_CFG;
            end else if (req_state == `FDIO_ST_SAFEOP && !out_ok) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_OUT_CFG;
            end else if (req_state == `FDIO_ST_SAFEOP && !in_ok) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_IN_CFG;
            end else begin
              state_nxt = req_state;
              err_flag_nxt = 1'b0;
              err_code_nxt = `FDIO_EC_NONE;
            end
          end
          `FDIO_ST_SAFEOP, `FDIO_ST_OP: begin
            if (req_state == `FDIO_ST_BOOT) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_BAD_CHANGE;
            end else if (req_state == `FDIO_ST_OP && !sync_ok) begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_SYNC_CFG;
            end else begin
              state_nxt = req_state;
              err_flag_nxt = 1'b0;
              err_code_nxt = `FDIO_EC_NONE;
            end
          end
          default: begin
            // boot may only fall back to init
            if (req_state == `FDIO_ST_INIT) begin
              state_nxt = req_state;
              err_flag_nxt = 1'b0;
              err_code_nxt = `FDIO_EC_NONE;
            end else begin
              err_flag_nxt = 1'b1;
              err_code_nxt = `FDIO_EC_BAD_CHANGE;
            end
          end
        endcase
      end
    end
    // hardware errors win over a request in the same cycle
    if (run_state && sync_watchdog_i) begin
      state_nxt = `FDIO_ST_SAFEOP;
      err_flag_nxt = 1'b1;
      err_code_nxt = `FDIO_EC_SYNC_WDOG;
    end else if (run_state && !in_ok) begin
      state_nxt = `FDIO_ST_PREOP;
      err_flag_nxt = 1'b1;
      err_code_nxt = `FDIO_EC_IN_CFG;
    end else if (run_state && !out_ok) begin
      state_nxt = `FDIO_ST_SAFEOP;
      err_flag_nxt = 1'b1;
      err_code_nxt = `FDIO_EC_OUT_CFG;
    end else if (app_fault_i) begin
      err_flag_nxt = 1'b1;
      err_code_nxt = `FDIO_EC_UNSPEC;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= `FDIO_ST_INIT;
      err_flag_r <= 1'b0;
      err_code_r <= `FDIO_EC_NONE;
    end else begin
      state_r <= state_nxt;
      err_flag_r <= err_flag_nxt;
      err_code_r <= err_code_nxt;
    end
  end

  // --------------------------------------------------------------------
  // connection watchdog
  // --------------------------------------------------------------------
  // timeout on link silence
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wdog_cnt_r <= 32'h00000000;
      timeout_r <= 1'b0;
    end else if (link_activity_i) begin
      wdog_cnt_r <= 32'h00000000;
      timeout_r <= 1'b0;
    end else if (wdog_cnt_r >= LINK_TIMEOUT_CYCLES - 1) begin
      timeout_r <= 1'b1;
    end else begin
      wdog_cnt_r <= wdog_cnt_r + 32'h00000001;
    end
  end

  assign link_timeout_o = timeout_r;

  // --------------------------------------------------------------------
  // process data update and timing
  // --------------------------------------------------------------------
  // delay counters started by the first sync pulse
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_cnt_r <= 16'h0000;
      out_busy_r <= 1'b0;
      in_cnt_r <= 16'h0000;
      in_busy_r <= 1'b0;
    end else begin
      if (dc_mode && first_sync_pulse_i) begin
        out_cnt_r <= delays_r[15:0];
        out_busy_r <= 1'b1;
        in_cnt_r <= delays_r[31:16];
        in_busy_r <= 1'b1;
      end else begin
        if (out_busy_r && out_cnt_r != 16'h0000)
          out_cnt_r <= out_cnt_r - 16'h0001;
        else
          out_busy_r <= 1'b0;
        if (in_busy_r && in_cnt_r != 16'h0000)
          in_cnt_r <= in_cnt_r - 16'h0001;
        else
          in_busy_r <= 1'b0;
      end
    end
  end

  wire out_due = out_busy_r & (out_cnt_r == 16'h0000);
  wire in_due = in_busy_r & (in_cnt_r == 16'h0000);
  wire out_upd = dc_mode ? out_due : frame_sync_event_i;
  wire in_upd = dc_mode ? in_due : 1'b1;

  // pin output register, safe values outside operational
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_r <= {CHANNELS{1'b0}};
    end else if (timeout_r || state_r != `FDIO_ST_OP) begin
      pin_out_r <= safe_val_r;
    end else if (out_upd) begin
      pin_out_r <= out_data_r;
    end
  end

  assign chan_out_o = pin_out_r & out_use_r;
  assign chan_out_en_o = out_use_r;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_in_r <= {CHANNELS{1'b0}};
    end else if (in_upd) begin
      pin_in_r <= (chan_in_i & ~out_use_r) | (chan_out_o & out_use_r);
    end
  end

  // --------------------------------------------------------------------
  // emergency messages
  // --------------------------------------------------------------------
  // lowest changed fault is reported first
  reg [5:0] fault_diff;
  reg [2:0] pick;
  reg found;
  integer k;
  always @* begin
    fault_diff = supply_fault_i ^ fault_rep_r;
    pick = 3'h0;
    found = 1'b0;
    for (k = 5; k >= 0; k = k - 1) begin
      if (fault_diff[k]) begin
        pick = k[2:0];
        found = 1'b1;
      end
    end
  end

  // register bits as they stand once the pick is reported
  wire [5:0] after_rep = fault_rep_r ^ (6'h01 << pick);
  wire [7:0] err_reg = {3'h0, after_rep[5], 1'b0, |after_rep[4:0], 2'h0};
  wire rising = supply_fault_i[pick];
  wire [15:0] em_code = !rising ? `FDIO_EM_RESET :
    (pick == `FDIO_EM_OVERTEMP_IDX) ? `FDIO_EM_OVERTEMP :
    `FDIO_EM_SUPPLY_BASE + {13'h0000, pick};
  wire [7:0] diag_n = {5'h00, pick} + 8'h01;

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_rep_r <= 6'h00;
      emcy_valid_r <= 1'b0;
      emcy_frame_r <= 64'h0000000000000000;
      emcy_idx_r <= 3'h0;
    end else if (emcy_valid_r) begin
      if (emcy_ready_i) begin
        emcy_valid_r <= 1'b0;
        fault_rep_r[emcy_idx_r] <= ~fault_rep_r[emcy_idx_r];
      end
    end else if (found) begin
      emcy_valid_r <= 1'b1;
      emcy_idx_r <= pick;
      emcy_frame_r <= {8'h00, 8'h00, 8'h00, diag_n, 8'h00, err_reg,
        em_code[15:8], em_code[7:0]};
    end
  end

  assign emcy_valid_o = emcy_valid_r;
  assign emcy_frame_o = emcy_frame_r;

endmodule // fdio_slave_app
`default_nettype wire

// file: fdio_slave_app_checker.sv
// port checker of the fieldbus digital i/o slave application block
// assumes binding to fdio_slave_app, one clock, active-low async reset
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// checker
// ----------------------------------------------------------------------
module fdio_slave_app_checker #(
  parameter LINK_TIMEOUT_CYCLES = 50000,
  parameter CHANNELS = 16
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic link_activity_i,
  input wire logic link_timeout_o,
  input wire logic [5:0] supply_fault_i,
  input wire logic emcy_valid_o,
  input wire logic [63:0] emcy_frame_o,
  input wire logic emcy_ready_i,
  input wire logic [CHANNELS-1:0] chan_out_o,
  input wire logic [CHANNELS-1:0] chan_out_en_o,
  input wire logic restore_defaults_o
);
  logic [31:0] idle_r;
  wire [15:0] code = emcy_frame_o[15:0];
  wire [7:0] num = emcy_frame_o[39:32];
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // cycles since the last link activity
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i)
      idle_r <= 32'h0;
    else if (link_activity_i)
      idle_r <= 32'h0;
    else
      idle_r <= idle_r + 32'h1;
  end
  sequence s_req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_emcy_stall;
    emcy_valid_o && !emcy_ready_i;
  endsequence
  a_bus_one_wait: assert property (s_req_wait |=> !avs_waitrequest_o)
    else $error("waitrequest held beyond one cycle");
  a_emcy_frame_held: assert property (s_emcy_stall |=> emcy_valid_o && $stable(emcy_frame_o))
    else $error("emergency dropped or changed before ready");
  a_emcy_pad_bytes: assert property (emcy_valid_o |-> emcy_frame_o[31:24] == 8'h00 && emcy_frame_o[63:40] == 24'h0)
    else $error("emergency diagnostic padding not zero");
  a_emcy_code_map: assert property (emcy_valid_o && code != 16'h0 |-> (num >= 8'h01 && num <= 8'h05 && code == 16'h3000 + num && emcy_frame_o[18]) || (num == 8'h06 && code == 16'h4001 && emcy_frame_o[20]))
    else $error("emergency code, register or index mismatch");
  a_emcy_clear_code: assert property (emcy_valid_o && code == 16'h0 |-> num >= 8'h01 && num <= 8'h06 && !(num == 8'h06 && emcy_frame_o[20]))
    else $error("clear message index or register wrong");
  a_emcy_on_change: assert property ($changed(supply_fault_i) && !emcy_valid_o |=> emcy_valid_o)
    else $error("fault change sent no emergency");
  a_out_only_enabled: assert property ((chan_out_o & ~chan_out_en_o) == '0)
    else $error("output driven on an input channel");
  a_timeout_due: assert property (idle_r == LINK_TIMEOUT_CYCLES |-> link_timeout_o)
    else $error("link timeout not flagged");
  a_restore_by_write: assert property ($changed(restore_defaults_o) |-> $past(avs_write_i && !avs_waitrequest_o))
    else $error("restore level changed without a write");
  a_dir_by_write: assert property ($changed(chan_out_en_o) |->
    $past(avs_write_i && !avs_waitrequest_o))
    else $error("channel direction changed without a write");
endmodule // fdio_slave_app_checker

bind fdio_slave_app fdio_slave_app_checker #(
  .LINK_TIMEOUT_CYCLES(LINK_TIMEOUT_CYCLES), .CHANNELS(CHANNELS)
) u_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .link_activity_i(link_activity_i), .link_timeout_o(link_timeout_o),
  .supply_fault_i(supply_fault_i), .emcy_valid_o(emcy_valid_o),
  .emcy_frame_o(emcy_frame_o), .emcy_ready_i(emcy_ready_i),
  .chan_out_o(chan_out_o), .chan_out_en_o(chan_out_en_o),
  .restore_defaults_o(restore_defaults_o)
);
`default_nettype wire

// file: fdio_master_model.sv
// fieldbus master model: link traffic, sync events, emergency sink
// assumes the clock and reset of the slave block
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// master model
// ----------------------------------------------------------------------
module fdio_master_model (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic link_en_i,
  input wire logic [3:0] stall_i,
  input wire logic emcy_valid_i,
  input wire logic [63:0] emcy_frame_i,
  output logic emcy_ready_o,
  output logic link_activity_o,
  output logic frame_sync_o,
  output logic [63:0] emcy_last_o,
  output logic [31:0] emcy_cnt_o
);
  logic [3:0] tick_r;
  logic [3:0] wait_r;
  // frames every 4 cycles, a sync event every 8, only while linked
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_r <= 4'h0;
      link_activity_o <= 1'b0;
      frame_sync_o <= 1'b0;
    end else begin
      tick_r <= tick_r + 4'h1;
      link_activity_o <= link_en_i && (tick_r[1:0] == 2'h0);
      frame_sync_o <= link_en_i && (tick_r[2:0] == 3'h4);
    end
  end
  // emergency sink, raises ready stall_i + 1 cycles after valid
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_r <= 4'h0;
      emcy_ready_o <= 1'b0;
      emcy_last_o <= 64'h0;
      emcy_cnt_o <= 32'h0;
    end else if (emcy_valid_i && emcy_ready_o) begin
      // frame kept as sent, byte 0 lowest
      emcy_last_o <= emcy_frame_i;
      emcy_cnt_o <= emcy_cnt_o + 32'h1;
      emcy_ready_o <= 1'b0;
      wait_r <= 4'h0;
    end else if (emcy_valid_i) begin
      wait_r <= wait_r + 4'h1;
      emcy_ready_o <= (wait_r >= stall_i);
    end
  end
endmodule // fdio_master_model
`default_nettype wire

// file: tb_fdio_slave_app.sv
// self-checking bench of the fieldbus digital i/o slave application
// assumes design, master model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "fdio_defs.vh"
// ----------------------------------------------------------------------
// bench top
// ----------------------------------------------------------------------
module tb_fdio_slave_app;
  logic clock_i, resetn_i, avs_read_i, avs_write_i, link_en;
  logic first_sync_pulse_i, sync_watchdog_i, app_fault_i;
  logic [5:0] avs_address_i, io_fault_i, supply_fault_i;
  logic [31:0] avs_writedata_i, rd;
  logic [15:0] chan_in_i;
  logic [3:0] stall;
  logic [63:0] e;
  wire [31:0] avs_readdata_o, emcy_cnt;
  wire [63:0] emcy_frame_o, emcy_last;
  wire [15:0] chan_out_o, chan_out_en_o;
  wire avs_waitrequest_o, emcy_valid_o, emcy_ready_i, restore_defaults_o;
  wire link_timeout_o, frame_sync_event_i, link_activity_i;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int i;
  logic [4:0] t_s [0:10] = '{5'h4, 5'h8, 5'h5, 5'h2, 5'h8, 5'h3, 5'h4,
    5'h3, 5'h8, 5'h3, 5'h18};
  logic [7:0] t_r [0:10] = '{8'h11, 8'h11, 8'h11, 8'h02, 8'h12, 8'h12,
    8'h04, 8'h14, 8'h08, 8'h18, 8'h08};
  logic [7:0] t_c [0:10] = '{8'h11, 8'h11, 8'h12, 8'h00, 8'h11, 8'h11,
    8'h00, 8'h11, 8'h00, 8'h11, 8'h00};

  fdio_slave_app #(.LINK_TIMEOUT_CYCLES(20)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .frame_sync_event_i(frame_sync_event_i),
    .first_sync_pulse_i(first_sync_pulse_i),
    .link_activity_i(link_activity_i), .sync_watchdog_i(sync_watchdog_i),
    .app_fault_i(app_fault_i), .chan_in_i(chan_in_i),
    .chan_out_o(chan_out_o), .chan_out_en_o(chan_out_en_o),
    .io_fault_i(io_fault_i), .supply_fault_i(supply_fault_i),
    .emcy_valid_o(emcy_valid_o), .emcy_frame_o(emcy_frame_o),
    .emcy_ready_i(emcy_ready_i), .restore_defaults_o(restore_defaults_o),
    .link_timeout_o(link_timeout_o));

  fdio_master_model u_master (
    .clock_i(clock_i), .resetn_i(resetn_i), .link_en_i(link_en),
    .stall_i(stall), .emcy_valid_i(emcy_valid_o), .emcy_frame_i(emcy_frame_o),
    .emcy_ready_o(emcy_ready_i), .link_activity_o(link_activity_i),
    .frame_sync_o(frame_sync_event_i), .emcy_last_o(emcy_last),
    .emcy_cnt_o(emcy_cnt));

  // 50 mhz clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    chk32(rd, x);
  endtask
  task automatic req(input logic [4:0] s, input logic [31:0] r, input logic [31:0] c);
    bus(1'b1, `FDIO_STATE_REQ_OFS, {27'h0, s});
    rdchk(`FDIO_STATE_REP_OFS, r);
    rdchk(`FDIO_ERR_CODE_OFS, c);
  endtask
  task automatic do_reset;
    resetn_i <= 1'b0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
  endtask
  task automatic emcy_chk(input logic [63:0] x);
    logic [31:0] k;
    k = emcy_cnt;
    while (emcy_cnt === k) @(posedge clock_i);
    chk64(emcy_last, x);
  endtask

  // main sequence
  initial begin
    resetn_i = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0;
    link_en = 1'b1;
    first_sync_pulse_i = 1'b0;
    sync_watchdog_i = 1'b0;
    app_fault_i = 1'b0;
    io_fault_i = 6'h2A;
    supply_fault_i = 6'h00;
    chan_in_i = 16'hABCD;
    stall = 4'h2;
    do_reset();
    rdchk(6'h0C, 32'h1E);
    bus(1'b1, 6'h3C, 32'hFFFF);
    rdchk(6'h3C, 32'h0);
    rdchk(6'h18, 32'h2A);
    bus(1'b1, 6'h1C, 32'h5A);
    bus(1'b1, 6'h20, 32'hFF);
    bus(1'b1, 6'h10, 32'h34);
    rdchk(6'h10, 32'h34);
    chk32({16'h0, chan_out_en_o}, 32'hFF);
    for (i = 0; i < 11; i++)
      req(t_s[i], {24'h0, t_r[i]}, {24'h0, t_c[i]});
    repeat (12) @(posedge clock_i);
    chk32({16'h0, chan_out_o}, 32'h34);
    rdchk(6'h14, 32'hAB34);
    link_en <= 1'b0;
    repeat (30) @(posedge clock_i);
    chk32({16'h0, chan_out_o}, 32'h5A);
    chk32({31'h0, link_timeout_o}, 32'h1);
    sync_watchdog_i <= 1'b1;
    @(posedge clock_i);
    sync_watchdog_i <= 1'b0;
    rdchk(6'h04, 32'h14);
    rdchk(6'h08, 32'h1B);
    app_fault_i <= 1'b1;
    @(posedge clock_i);
    app_fault_i <= 1'b0;
    rdchk(6'h08, 32'h01);
    bus(1'b1, 6'h0C, 32'h1A);
    req(5'h8, 32'h14, 32'h17);
    bus(1'b1, 6'h0C, 32'h0E);
    rdchk(6'h04, 32'h12);
    rdchk(6'h08, 32'h1E);
    bus(1'b1, 6'h0C, 32'h16);
    req(5'h4, 32'h12, 32'h1D);
    bus(1'b1, 6'h28, 32'h1);
    @(posedge clock_i);
    chk32({31'h0, restore_defaults_o}, 32'h1);
    bus(1'b1, 6'h28, 32'h2);
    rdchk(6'h28, 32'h0);
    link_en <= 1'b1;
    do_reset();
    bus(1'b1, 6'h0C, 32'h1C);
    req(5'h2, 32'h11, 32'h16);
    req(5'h3, 32'h11, 32'h15);
    bus(1'b1, 6'h0C, 32'h1F);
    req(5'h3, 32'h03, 32'h0);
    req(5'h2, 32'h13, 32'h11);
    req(5'h1, 32'h01, 32'h0);
    bus(1'b1, 6'h24, 32'h0005_0003);
    bus(1'b1, 6'h20, 32'hFF);
    bus(1'b1, 6'h10, 32'hC3);
    req(5'h2, 32'h02, 32'h0);
    req(5'h4, 32'h04, 32'h0);
    req(5'h8, 32'h08, 32'h0);
    repeat (12) @(posedge clock_i);
    chk32({16'h0, chan_out_o}, 32'h0);
    first_sync_pulse_i <= 1'b1;
    @(posedge clock_i);
    first_sync_pulse_i <= 1'b0;
    chan_in_i <= 16'h2200;
    repeat (4) @(posedge clock_i);
    chk32({16'h0, chan_out_o}, 32'h0);
    @(posedge clock_i);
    chk32({16'h0, chan_out_o}, 32'hC3);
    @(posedge clock_i);
    chan_in_i <= 16'h4400;
    rdchk(6'h14, 32'h22C3);
    for (i = 0; i < 6; i++) begin
      stall <= i[3:0];
      supply_fault_i <= 6'h01 << i;
      e = {24'h0, 8'(i + 1), 8'h00, (i < 5) ? 8'h04 : 8'h10,
        (i < 5) ? 16'h3001 + 16'(i) : 16'h4001};
      emcy_chk(e);
      supply_fault_i <= 6'h00;
      e[23:0] = 24'h0;
      emcy_chk(e);
    end
    complete_run();
  end
endmodule // tb_fdio_slave_app
`default_nettype wire
